//--- logic/bit_fifo.sv
`timescale 1ns/1ns
module bit_fifo #(
   parameter int W = 1,
   parameter int DEPTH = 2
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // streams
   ir_stream_if.consumer in_s,
   ir_stream_if.producer out_s
);
   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

   if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0)
   begin : g_bad_depth
      $error("bit_fifo depth must be a power of two, at least 2");
   end

   logic [W-1:0] mem_reg [DEPTH];
   logic [AW-1:0] wptr_reg;
   logic [AW-1:0] rptr_reg;
   logic [AW:0] count_reg;
   wire push = in_s.valid && in_s.ready;
   wire pop = out_s.valid && out_s.ready;

   assign in_s.ready = (count_reg != (AW+1)'(DEPTH));
   assign out_s.valid = (count_reg != '0);
   assign out_s.data = mem_reg[rptr_reg];

   always_ff @(posedge clk)
   begin
      if (push)
         mem_reg[wptr_reg] <= in_s.data;
   end

   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         wptr_reg <= '0;
         rptr_reg <= '0;
         count_reg <= '0;
      end
      else
      begin
         wptr_reg <= wptr_reg + AW'(push);
         rptr_reg <= rptr_reg + AW'(pop);
         count_reg <= count_reg + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule : bit_fifo

//--- logic/infrared_pulse_codec.sv
// Summary of operation
// - With run_in_debug_halt clear the stage freezes and ignores events while the processor is halted.
// - With run_in_debug_halt set the stage keeps running during a debug halt.
// - Setting infrared_event_input_enable makes the event channel the receive source.
// - While the event input is selected the receive pin is cut off from the receiver.
// - A transmit pulse length of zero gives pulses of 3/16 of a baud period.
// - A transmit pulse length of 1 to 254 gives pulses of that many clocks.
// - Every transmit pulse starts on a baud clock rising edge.
// - A transmit pulse length of 255 passes transmit and receive through unchanged.
// - The pulse length settings only act when the infrared mode is selected.
// - A receive pulse length of zero applies no filtering.
// - A receive pulse length x accepts a pulse after x+1 equal samples.
// - Communication mode code 0x2 selects infrared operation.
`timescale 1ns/1ns
`include "ir_consts.svh"
module infrared_pulse_codec #(
   parameter int FIFO_DEPTH = 2
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // register port
   input wire logic [3:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   // serial port context
   input wire logic [1:0] communication_mode,
   input wire logic debug_halted,
   input wire logic baud_tick,
   input wire logic os_tick,
   // transmit bit stream from the serial port
   input wire logic tx_bit,
   input wire logic tx_valid,
   output logic tx_ready,
   // receive line to the serial port
   output logic rx_line,
   // pins and event channel
   output logic tx_pin,
   input wire logic rx_pin,
   input wire logic event_in
);
   // register file
   logic run_in_debug_halt;
   logic infrared_event_input_enable;
   logic [7:0] transmit_pulse_length;
   logic [6:0] receive_pulse_length;
   logic [7:0] rdata_reg;

   // datapath state
   ir_pkg::tx_state_t tx_state_reg;
   ir_pkg::tx_state_t tx_state_next;
   logic [7:0] pcnt_reg;
   logic [7:0] pcnt_next;
   logic bit_reg;
   logic tx_pin_reg;
   logic tx_pin_next;
   logic rx_meta_reg;
   logic rx_sync_reg;
   logic filt_prev_reg;
   logic [4:0] stretch_reg;
   logic [4:0] stretch_next;
   logic rx_line_reg;
   logic rx_line_next;
   logic filt;
   logic [6:0] filt_run;

   ir_stream_if #(.W(1)) tx_in_s ();
   ir_stream_if #(.W(1)) tx_out_s ();

   // decode
   wire halt = debug_halted && !run_in_debug_halt;
   wire infrared_mode = (communication_mode == ir_pkg::COMM_INFRARED);
   wire coding = infrared_mode && (transmit_pulse_length != `IR_TX_LEN_OFF);
   wire sixteenths = (transmit_pulse_length == `IR_TX_LEN_SIXTEENTHS);
   wire wr_debug = reg_wr && (reg_addr == `IR_ADDR_DEBUG);
   wire wr_event = reg_wr && (reg_addr == `IR_ADDR_EVENT);
   wire wr_tx_len = reg_wr && (reg_addr == `IR_ADDR_TX_LEN);
   wire wr_rx_len = reg_wr && (reg_addr == `IR_ADDR_RX_LEN);
   wire tx_pop = baud_tick && !halt;
   wire new_bit = tx_out_s.valid ? tx_out_s.data[0] : 1'b1;
   wire pulse_start = tx_pop && !new_bit;
   wire pulse_step = sixteenths ? os_tick : 1'b1;
   wire [7:0] pulse_len = sixteenths ? `IR_SIXTEENTHS_PULSE
                                     : transmit_pulse_length;
   wire rx_src = infrared_event_input_enable ? event_in : rx_sync_reg;
   wire filt_rise = filt && !filt_prev_reg;

   assign tx_in_s.valid = tx_valid;
   assign tx_in_s.data = tx_bit;
   assign tx_ready = tx_in_s.ready;
   assign tx_out_s.ready = tx_pop;
   assign tx_pin = tx_pin_reg;
   assign rx_line = rx_line_reg;
   assign reg_rdata = rdata_reg;

   // read mux; unmapped offsets read zero
   wire [7:0] rd_mux =
      (reg_addr == `IR_ADDR_DEBUG) ? {7'h00, run_in_debug_halt} :
      (reg_addr == `IR_ADDR_EVENT) ? {7'h00, infrared_event_input_enable} :
      (reg_addr == `IR_ADDR_TX_LEN) ? transmit_pulse_length :
      (reg_addr == `IR_ADDR_RX_LEN) ? {1'b0, receive_pulse_length} :
      (reg_addr == `IR_ADDR_STATUS) ?
         {4'h0, tx_out_s.valid, halt, rx_line_reg, tx_pin_reg} : 8'h00;

   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         run_in_debug_halt <= 1'(`IR_DEBUG_RST);
         infrared_event_input_enable <= 1'(`IR_EVENT_RST);
         transmit_pulse_length <= `IR_TX_LEN_RST;
         receive_pulse_length <= `IR_RX_LEN_RST;
      end
      else
      begin
         if (wr_debug)
            run_in_debug_halt <= reg_wdata[`IR_RUN_BIT];
         if (wr_event)
            infrared_event_input_enable <= reg_wdata[`IR_EVEN_BIT];
         if (wr_tx_len)
            transmit_pulse_length <= reg_wdata;
         if (wr_rx_len)
            receive_pulse_length <= reg_wdata[6:0];
      end
   end

   // data stands only in the cycle after the strobe
   always_ff @(posedge clk)
   begin
      if (!rst_n)
         rdata_reg <= 8'h00;
      else
         rdata_reg <= reg_rd ? rd_mux : 8'h00;
   end

   // stall by the baud clock back-pressures the serial port
   bit_fifo #(.W(1), .DEPTH(FIFO_DEPTH)) u_tx_fifo (
      .clk(clk),
      .rst_n(rst_n),
      .in_s(tx_in_s.consumer),
      .out_s(tx_out_s.producer)
   );

   // pulse length counter; a new start always reloads it
   always_comb
   begin
      tx_state_next = tx_state_reg;
      pcnt_next = pcnt_reg;
      if (halt)
         pcnt_next = pcnt_reg;
      else if (pulse_start && coding)
      begin
         tx_state_next = ir_pkg::TX_PULSE;
         pcnt_next = pulse_len;
      end
      else if (tx_state_reg == ir_pkg::TX_PULSE && pulse_step)
      begin
         pcnt_next = pcnt_reg - 8'h01;
         if (pcnt_reg == 8'h01)
            tx_state_next = ir_pkg::TX_IDLE;
      end
      unique case (tx_state_next)
         ir_pkg::TX_IDLE: tx_pin_next = coding ? 1'b0 : bit_reg;
         ir_pkg::TX_PULSE: tx_pin_next = coding;
      endcase
      if (!coding)
         tx_pin_next = tx_pop ? new_bit : bit_reg;
   end

   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         tx_state_reg <= ir_pkg::TX_IDLE;
         pcnt_reg <= 8'h00;
         bit_reg <= 1'b1;
         tx_pin_reg <= 1'b0;
      end
      else
      begin
         tx_state_reg <= tx_state_next;
         pcnt_reg <= pcnt_next;
         if (tx_pop)
            bit_reg <= new_bit;
         tx_pin_reg <= tx_pin_next;
      end
   end

   // receive pin crosses in from outside
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         rx_meta_reg <= 1'b1;
         rx_sync_reg <= 1'b1;
      end
      else
      begin
         rx_meta_reg <= rx_pin;
         rx_sync_reg <= rx_meta_reg;
      end
   end

   // frozen during a halt, so events then go unseen
   sample_filter #(.LW(7)) u_rx_filter (
      .clk(clk),
      .rst_n(rst_n),
      .en(!halt),
      .din(rx_src),
      .len(receive_pulse_length),
      .dout(filt),
      .run(filt_run)
   );

   // a received pulse is stretched to one bit of low level
   always_comb
   begin
      stretch_next = stretch_reg;
      if (filt_rise)
         stretch_next = `IR_OS_PER_BAUD;
      else if (os_tick && stretch_reg != 5'h00)
         stretch_next = stretch_reg - 5'h01;
      rx_line_next = coding ? (stretch_next == 5'h00) : rx_src;
   end

   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         filt_prev_reg <= 1'b0;
         stretch_reg <= 5'h00;
         rx_line_reg <= 1'b1;
      end
      else if (!halt)
      begin
         filt_prev_reg <= filt;
         stretch_reg <= stretch_next;
         rx_line_reg <= rx_line_next;
      end
   end

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);

   sequence s_pulse_start;
      coding && !halt && pulse_start;
   endsequence

   a_halt_freeze: assert property (
      halt && $past(halt) |-> $stable(pcnt_reg) && $stable(rx_line_reg))
      else $error("stage moved during debug halt");

   a_run_in_halt: assert property (
      debug_halted && run_in_debug_halt && baud_tick |-> tx_out_s.ready)
      else $error("stage stalled although run in halt is set");

   a_event_source: assert property (
      infrared_event_input_enable |-> rx_src == event_in)
      else $error("event channel not selected as receive source");

   a_pin_cut_off: assert property (
      infrared_event_input_enable && !halt && !coding
      ##1 $changed(rx_sync_reg) && $stable(event_in)
      && infrared_event_input_enable |=> $stable(rx_line_reg))
      else $error("receive pin reached receiver with event input on");

   a_sixteenths_len: assert property (
      s_pulse_start and sixteenths |=> tx_pin_reg
      && pcnt_reg == `IR_SIXTEENTHS_PULSE)
      else $error("3/16 pulse loaded with wrong length");

   a_fixed_len: assert property (
      s_pulse_start and !sixteenths |=> tx_pin_reg [*1]
      ##0 pcnt_reg == $past(transmit_pulse_length))
      else $error("fixed pulse loaded with wrong length");

   a_fixed_end: assert property (
      coding && !sixteenths && !halt && pcnt_reg == 8'h01
      && tx_state_reg == ir_pkg::TX_PULSE && !pulse_start
      |=> !tx_pin_reg)
      else $error("fixed pulse did not end on time");

   a_pulse_aligned: assert property (
      coding && $rose(tx_pin_reg) |-> $past(tx_pop))
      else $error("pulse started away from a baud edge");

   a_pass_through: assert property (
      !coding && tx_pop ##1 !coding |-> tx_pin_reg == $past(new_bit))
      else $error("uncoded transmit bit altered");

   a_mode_gate: assert property (
      !infrared_mode && !halt ##1 !infrared_mode
      |-> rx_line_reg == $past(rx_src))
      else $error("pulse settings acted outside infrared mode");

   a_no_filter: assert property (
      receive_pulse_length == 7'h00 && !halt |=> filt == $past(rx_src))
      else $error("filter active with zero length");

   a_filter_run: assert property (
      !$past(halt) && $changed(filt) |->
      $past(filt_run) == $past(receive_pulse_length)
      && filt == $past(rx_src))
      else $error("filter accepted before x+1 samples");

endmodule : infrared_pulse_codec

//--- logic/ir_consts.svh
`ifndef IR_CONSTS_SVH
`define IR_CONSTS_SVH

// register offsets
`define IR_ADDR_DEBUG 4'hb
`define IR_ADDR_EVENT 4'hc
`define IR_ADDR_TX_LEN 4'hd
`define IR_ADDR_RX_LEN 4'he
`define IR_ADDR_STATUS 4'hf

// field positions
`define IR_RUN_BIT 0
`define IR_EVEN_BIT 0

// reset values
`define IR_DEBUG_RST 8'h00
`define IR_EVENT_RST 8'h00
`define IR_TX_LEN_RST 8'h00
`define IR_RX_LEN_RST 7'h00

// pulse coding
`define IR_TX_LEN_SIXTEENTHS 8'h00
`define IR_TX_LEN_OFF 8'hff
`define IR_SIXTEENTHS_PULSE 8'h03
`define IR_OS_PER_BAUD 5'h10

`endif

//--- logic/ir_pkg.sv
package ir_pkg;

   typedef enum logic [1:0]
   {
      COMM_ASYNC,
      COMM_SYNC,
      COMM_INFRARED,
      COMM_MSPI
   } comm_mode_t;

   typedef enum logic
   {
      TX_IDLE,
      TX_PULSE
   } tx_state_t;

endpackage : ir_pkg

//--- logic/ir_stream_if.sv
`timescale 1ns/1ns
interface ir_stream_if #(parameter int W = 1);
   logic valid;
   logic ready;
   logic [W-1:0] data;

   modport producer (output valid, output data, input ready);
   modport consumer (input valid, input data, output ready);
endinterface : ir_stream_if

//--- logic/sample_filter.sv
`timescale 1ns/1ns
module sample_filter #(
   parameter int LW = 7
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // samples
   input wire logic en,
   input wire logic din,
   input wire logic [LW-1:0] len,
   output logic dout,
   output logic [LW-1:0] run
);
   if (LW < 1)
   begin : g_bad_width
      $error("sample_filter length width must be at least 1");
   end

   logic dout_reg;
   logic [LW-1:0] run_reg;
   // a differing sample only wins after len+1 of them in a row
   wire differ = (din != dout_reg);
   wire accept = differ && (run_reg == len);

   assign dout = dout_reg;
   assign run = run_reg;

   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         dout_reg <= 1'b0;
         run_reg <= '0;
      end
      else if (en)
      begin
         if (accept)
            dout_reg <= din;
         run_reg <= (differ && !accept) ? run_reg + 1'b1 : '0;
      end
   end
endmodule : sample_filter

//--- verification/ir_xcvr.sv
`timescale 1ns/1ns
module ir_xcvr (
   // clock
   input wire logic clk,
   // infrared pins, seen from the transceiver
   input wire logic tx_pin,
   output logic rx_pin
);
   int hi_len = 0;
   int last_len = 0;
   initial
   begin
      rx_pin = 1'b0;
   end
   // length of the latest light pulse, known once it has ended
   always @(posedge clk)
   begin
      if (tx_pin === 1'b1)
         hi_len <= hi_len + 1;
      else if (hi_len != 0)
      begin
         last_len <= hi_len;
         hi_len <= 0;
      end
   end
   task automatic level(input logic l);
      rx_pin <= l;
   endtask : level
   // call on a rising edge; inverse of idle for w clocks
   task automatic pulse(input int w, input logic idle);
      rx_pin <= ~idle;
      repeat (w) @(posedge clk);
      rx_pin <= idle;
   endtask : pulse
endmodule : ir_xcvr

//--- verification/tb_top.sv
`timescale 1ns/1ns
module tb_top;
   // long oversample period keeps the baud period above 255 clocks
   localparam int OSD = 20;
   logic clk, rst_n, reg_wr, reg_rd, tx_bit, tx_valid, tx_ready;
   logic debug_halted, baud_tick, os_tick, rx_line, tx_pin, rx_pin;
   logic event_in, s;
   logic [3:0] reg_addr;
   logic [7:0] reg_wdata, reg_rdata, v;
   logic [1:0] communication_mode;
   int bad_count = 0, check_count = 0, seed, w, osc = 0, osn = 0;
   int q[$];
   int pls[5];
   int m[16];

   infrared_pulse_codec uut (.clk(clk), .rst_n(rst_n),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .communication_mode(communication_mode),
      .debug_halted(debug_halted), .baud_tick(baud_tick),
      .os_tick(os_tick), .tx_bit(tx_bit), .tx_valid(tx_valid),
      .tx_ready(tx_ready), .rx_line(rx_line), .tx_pin(tx_pin),
      .rx_pin(rx_pin), .event_in(event_in));
   ir_xcvr xcvr (.clk(clk), .tx_pin(tx_pin), .rx_pin(rx_pin));

   initial
   begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   // baud tick lands on every sixteenth oversample tick
   always @(posedge clk)
   begin
      os_tick <= (osc == OSD - 1);
      baud_tick <= (osc == OSD - 1) && (osn == 15);
      osc <= (osc == OSD - 1) ? 0 : osc + 1;
      if (osc == OSD - 1)
         osn <= (osn + 1) % 16;
   end

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      check_count++;
      if (got !== exp)
      begin
         bad_count++;
         $display("BAD t=%0t seen=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic end_of_test;
      $display("checks=%0d mismatches=%0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : end_of_test
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
      // one idle edge keeps a following write from re-raising the strobe
      @(posedge clk);
   endtask : wr
   task automatic rd(input logic [3:0] a, output logic [7:0] d);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      @(posedge clk);
      d = reg_rdata;
   endtask : rd
   task automatic wait_baud;
      do @(posedge clk); while (baud_tick !== 1'b1);
   endtask : wait_baud
   task automatic send(input logic b);
      @(posedge clk);
      tx_bit <= b;
      tx_valid <= 1'b1;
      do @(posedge clk); while (tx_ready !== 1'b1);
      tx_valid <= 1'b0;
   endtask : send
   // sel 0: watch for a low receive line, sel 1: for a high tx pin
   task automatic look(input int n, input bit sel, output logic f);
      f = 1'b0;
      repeat (n)
      begin
         @(posedge clk);
         if (sel ? tx_pin === 1'b1 : rx_line === 1'b0)
            f = 1'b1;
      end
   endtask : look
   task automatic tx_case(input int pl, input logic [1:0] md);
      wr(4'hd, 8'(pl));
      communication_mode <= md;
      wait_baud;
      send(1'b0);
      q.push_back(pl == 0 ? 3 * OSD : pl);
      wait_baud;
      if (md == 2'h2 && pl != 255)
      begin
         #1 chk(tx_pin, 1);
         repeat (16 * OSD - 20) @(posedge clk);
         chk(16'(xcvr.last_len), 16'(q.pop_front()));
      end
      else
      begin
         #1 chk(tx_pin, 0);
         void'(q.pop_front());
         wait_baud;
         #1 chk(tx_pin, 1);
         @(posedge clk);
      end
      $display("tx case %0d mode %0d done", pl, md);
   endtask : tx_case
   task automatic rx_case(input int x, input int pw, input logic acc);
      wr(4'he, 8'(x));
      fork
         xcvr.pulse(pw, 1'b0);
         look(pw + 12, 0, s);
      join
      chk(s, acc);
      repeat (17 * OSD) @(posedge clk);
      $display("rx case %0d width %0d done", x, pw);
   endtask : rx_case

   initial
   begin
      repeat (40000) @(posedge clk);
      bad_count++;
      end_of_test;
   end

   initial
   begin
      seed = 58931;
      rst_n = 1'b0;
      {reg_addr, reg_wdata, reg_wr, reg_rd, tx_bit, tx_valid} = '0;
      {debug_halted, communication_mode} = '0;
      event_in = 1'b1;
      repeat (16) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      foreach (m[a])
         m[a] = 0;
      for (int p = 0; p < 2; p++)
      begin
         for (int a = 10; a <= 14; a++)
         begin
            rd(4'(a), v);
            chk(v, 16'(m[a]));
         end
         for (int a = 11; a <= 14; a++)
         begin
            v = 8'($random(seed));
            wr(4'(a), v);
            m[a] = v & (a == 14 ? 8'h7f : a < 13 ? 8'h01 : 8'hff);
         end
      end
      $display("register test done");
      wr(4'hb, 8'h00);
      wr(4'hc, 8'h00);
      w = 1 + ($unsigned($random(seed)) % 253);
      pls = '{0, 1, 254, w, 255};
      foreach (pls[i])
         tx_case(pls[i], 2'h2);
      for (int md = 0; md < 4; md++)
         if (md != 2)
            tx_case(4, 2'(md));
      // halted with run bit clear: the queued bit must wait
      communication_mode <= 2'h2;
      debug_halted <= 1'b1;
      wait_baud;
      send(1'b0);
      look(2 * 16 * OSD, 1, s);
      chk(s, 0);
      // a second held bit fills the buffer while nothing drains
      send(1'b0);
      @(posedge clk);
      chk(tx_ready, 1'b0);
      debug_halted <= 1'b0;
      wait_baud;
      #1 chk(tx_pin, 1);
      @(posedge clk);
      wr(4'hb, 8'h01);
      debug_halted <= 1'b1;
      wait_baud;
      send(1'b0);
      wait_baud;
      #1 chk(tx_pin, 1);
      @(posedge clk);
      debug_halted <= 1'b0;
      $display("debug halt test done");
      wr(4'hd, 8'h04);
      rx_case(0, 1, 1'b1);
      rx_case(3, 3, 1'b0);
      rx_case(3, 4, 1'b1);
      // uncoded: pin filtering off and event source selectable
      communication_mode <= 2'h0;
      xcvr.level(1'b1);
      wr(4'hc, 8'h01);
      repeat (4) @(posedge clk);
      event_in <= 1'b0;
      repeat (2) @(posedge clk);
      chk(rx_line, 0);
      event_in <= 1'b1;
      repeat (3) @(posedge clk);
      fork
         xcvr.pulse(6, 1'b1);
         look(12, 0, s);
      join
      chk(s, 0);
      wr(4'hb, 8'h00);
      debug_halted <= 1'b1;
      event_in <= 1'b0;
      look(6, 0, s);
      chk(s, 0);
      event_in <= 1'b1;
      debug_halted <= 1'b0;
      wr(4'hc, 8'h00);
      repeat (3) @(posedge clk);
      fork
         xcvr.pulse(2, 1'b1);
         look(10, 0, s);
      join
      chk(s, 1);
      $display("receive source test done");
      end_of_test;
   end
endmodule : tb_top
